// ### logic/lhm_pkg.sv
/*
 constants shared by the loop-hold and metronome controller.
 assumes a 40 MHz system clock; counts above 4096 cycles are module
 parameters whose defaults come from the figures here.
*/
// Functional notes
// - loop-hold recirculates the whole sample memory, never a shorter part.
// - captured loop length ignores the delay tap position.
// - loop length changes through sample rate (sweep or doubling button) and memory extension.
// - up held then down pressed ramps tap to maximum within five seconds.
// - maximum tap makes write-to-read distance equal the loop length.
// - half or quarter tap gives two or four echoes per memory cycle.
// - tap and loop both count samples, so rate changes scale both.
// - leaving loop-hold resumes feedback recirculation, memory kept.
// - metronome period is a selectable fraction of loop length.
// - metronome interval is independent of the delay tap.
// - each metronome pulse lights the lamp and drives the clock output.
// - loop-hold entry or exit waits for the next metronome pulse.
// - memory gives 2400 ms base, 4800 ms with extension, nominal rate.
// - metronome ratio is one half after reset.
// - up in ratio mode halves ratio to 1/64 then wraps; auto-step 1 s.
// - down in ratio mode cycles numerator through 1, 3, 5, 7, 9.
`default_nettype none
package lhm_pkg;
   localparam int CLK_HZ = 40000000;
   // nominal sample rate and memory times
   localparam int SAMPLE_HZ = 27307;
   localparam int MEM_MS_BASE = 2400;
   localparam int MEM_MS_EXT = 4800;
   localparam int ADDR_W = 17;
   localparam logic [ADDR_W-1:0] MEM_LEN_BASE = 17'h10000;
   localparam logic [ADDR_W:0] MEM_LEN_EXT = 18'h20000;
   localparam int DATA_W = 16;
   // tap is held as a fraction of the loop, TAP_FULL meaning the whole loop
   localparam int TAP_W = 9;
   localparam logic [TAP_W-1:0] TAP_FULL = 9'h100;
   localparam int TAP_SHIFT = 8;
   localparam logic [TAP_W-1:0] TAP_RESET = 9'h080;
   // timing figures
   localparam int RAMP_S = 5;
   localparam int RAMP_CYC = (RAMP_S * CLK_HZ) / 256;
   localparam int AUTO_MS = 1000;
   localparam int AUTO_CYC = (AUTO_MS / 1000) * CLK_HZ;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int PULSE_MS = 1;
   localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
   // ratio after reset: 1/2
   localparam logic [2:0] NUM_RESET = 3'h0;
   localparam logic [2:0] DEN_RESET = 3'h1;
   localparam logic [2:0] DEN_LAST = 3'h6;
   localparam logic [2:0] NUM_LAST = 3'h4;
   // button indexes
   localparam int BTN_N = 3;
   localparam int BTN_UP = 0;
   localparam int BTN_DOWN = 1;
   localparam int BTN_HOLD = 2;
   typedef enum logic [1:0] {
      LHM_NORMAL = 2'b00,
      LHM_HOLD = 2'b01
   } lhm_mode_e;
endpackage : lhm_pkg
`default_nettype wire

// ### logic/lhm_skid_buf.sv
/*
 two-entry buffer with valid and ready on both sides.
 assumes one clock; source and sink are in that domain.
*/
`default_nettype none
module lhm_skid_buf #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   logic [W-1:0] mem_q [2];
   logic rdPtr_q;
   logic wrPtr_q;
   logic [1:0] cnt_q;
   wire doPush = inValid && inReady;
   wire doPop = outValid && outReady;

   assign inReady = (cnt_q != 2'h2);
   assign outValid = (cnt_q != 2'h0);
   assign outData = mem_q[rdPtr_q];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdPtr_q <= 1'b0;
         wrPtr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (doPush) wrPtr_q <= ~wrPtr_q;
         if (doPop) rdPtr_q <= ~rdPtr_q;
         if (doPush && !doPop) cnt_q <= cnt_q + 2'h1;
         else if (doPop && !doPush) cnt_q <= cnt_q - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (doPush) mem_q[wrPtr_q] <= inData;
   end
endmodule : lhm_skid_buf
`default_nettype wire

// ### logic/lhm_loop_ctrl.sv
/*
 loop-hold, delay tap and metronome control for the delay line.
 assumes sampleTick is a one-cycle pulse on clk at the swept sample rate,
 the sample memory is external with combinational read data, and buttons
 are raw pins.
*/
`default_nettype none
module lhm_loop_ctrl #(
   parameter int RAMP_CYC = lhm_pkg::RAMP_CYC,
   parameter int AUTO_CYC = lhm_pkg::AUTO_CYC,
   parameter int DEBOUNCE_CYC = lhm_pkg::DEBOUNCE_CYC,
   parameter int PULSE_CYC = lhm_pkg::PULSE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // front panel
   input wire logic stepUpBtn,
   input wire logic stepDownBtn,
   input wire logic holdBtn,
   input wire logic setModeClk,
   input wire logic delayDoublingButton,
   input wire logic memExtFitted,
   // sample timing
   input wire logic sampleTick,
   // sample memory
   output logic [lhm_pkg::ADDR_W-1:0] memWrAddr,
   output logic [lhm_pkg::ADDR_W-1:0] memRdAddr,
   output logic memRdEn,
   output logic memWrEn,
   output logic memWrRecirc,
   input wire logic [lhm_pkg::DATA_W-1:0] memRdData,
   // delayed output stream
   output logic echoValid,
   input wire logic echoReady,
   output logic [lhm_pkg::DATA_W-1:0] echoData,
   // status
   output logic holdActive,
   output logic [lhm_pkg::TAP_W-1:0] tapLevel,
   output logic [2:0] ratioNumSel,
   output logic [2:0] ratioDenSel,
   output logic clkLamp,
   output logic clkOutPulse
);
   localparam int AW = lhm_pkg::ADDR_W;

   // ------------------------------------------------------------
   // button synchronise and debounce
   // ------------------------------------------------------------
   wire [lhm_pkg::BTN_N-1:0] btnRaw = {holdBtn, stepDownBtn, stepUpBtn};
   logic [lhm_pkg::BTN_N-1:0] btnLvl;
   logic [lhm_pkg::BTN_N-1:0] btnPress;
   genvar gi;
   generate
      for (gi = 0; gi < lhm_pkg::BTN_N; gi++) begin : g_btn
         logic s1_q;
         logic s2_q;
         logic st_q;
         logic prev_q;
         logic [22:0] db_q;
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               st_q <= 1'b0;
               prev_q <= 1'b0;
               db_q <= '0;
            end else begin
               s1_q <= btnRaw[gi];
               s2_q <= s1_q;
               prev_q <= st_q;
               if (s2_q == st_q) db_q <= '0;
               else if (db_q == 23'(DEBOUNCE_CYC - 1)) begin
                  st_q <= s2_q;
                  db_q <= '0;
               end else db_q <= db_q + 23'h1;
            end
         end
         assign btnLvl[gi] = st_q;
         assign btnPress[gi] = st_q && !prev_q;
      end
   endgenerate

   wire upLvl = btnLvl[lhm_pkg::BTN_UP];
   wire downLvl = btnLvl[lhm_pkg::BTN_DOWN];
   wire upPress = btnPress[lhm_pkg::BTN_UP];
   wire downPress = btnPress[lhm_pkg::BTN_DOWN];
   wire holdPress = btnPress[lhm_pkg::BTN_HOLD];

   // ------------------------------------------------------------
   // mode switch and doubling button: two-stage synchronisers
   // ------------------------------------------------------------
   logic [1:0] modeSync_q;
   logic [1:0] dblSync_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         modeSync_q <= 2'h0;
         dblSync_q <= 2'h0;
      end else begin
         modeSync_q <= {modeSync_q[0], setModeClk};
         dblSync_q <= {dblSync_q[0], delayDoublingButton};
      end
   end
   wire ratioMode = modeSync_q[1];
   wire dblOn = dblSync_q[1];

   // ------------------------------------------------------------
   // sample enable: doubling halves the rate, loop length in samples kept
   // ------------------------------------------------------------
   logic halfPh_q;
   logic tickPend_q;
   wire rateTick = sampleTick && (!dblOn || halfPh_q);
   logic bufReady;
   wire advance = tickPend_q && bufReady;

   // ------------------------------------------------------------
   // tap stepping, chord ramp and auto-repeat
   // ------------------------------------------------------------
   logic [lhm_pkg::TAP_W-1:0] tap_q;
   logic chord_q;
   logic [25:0] rpt_q;
   wire tapMode = !ratioMode;
   wire chordNow = chord_q && upLvl && downLvl;
   wire rptLimit = chordNow ? (rpt_q == 26'(RAMP_CYC - 1))
                            : (rpt_q == 26'(AUTO_CYC - 1));
   wire tapAtMax = (tap_q == lhm_pkg::TAP_FULL);
   wire tapAtMin = (tap_q == 9'h001);
   wire incTap = tapMode && !tapAtMax
      && ((upPress && !downLvl) || (rptLimit && upLvl && !downLvl)
          || (chordNow && rptLimit));
   wire decTap = tapMode && !tapAtMin && !upLvl
      && (downPress || (rptLimit && downLvl));

   // ------------------------------------------------------------
   // ratio selection
   // ------------------------------------------------------------
   logic [2:0] num_q;
   logic [2:0] den_q;
   wire ratioUp = ratioMode && (upPress || (upLvl && rptLimit));
   wire ratioDown = ratioMode && downPress;
   wire [3:0] numVal = {num_q, 1'b1};

   // ------------------------------------------------------------
   // addressing: full memory always cycles, tap sets read distance
   // ------------------------------------------------------------
   logic [AW-1:0] wr_q;
   wire [AW:0] memLen = memExtFitted ? lhm_pkg::MEM_LEN_EXT
                                     : {1'b0, lhm_pkg::MEM_LEN_BASE};
   wire [AW-1:0] addrMask = memExtFitted ? {AW{1'b1}} : {1'b0, {(AW-1){1'b1}}};
   wire [AW:0] tapDist = (AW+1)'(({8'h00, memLen} * {17'h0, tap_q})
                             >> lhm_pkg::TAP_SHIFT) ;
   wire [AW-1:0] tapRdAddr = (wr_q - tapDist[AW-1:0]) & addrMask;
   // in hold the read trails the write by the whole memory, tap ignored
   wire [AW-1:0] rdAddr = holdActive ? wr_q : tapRdAddr;
   wire wrapNow = ((wr_q + 17'h1) & addrMask) == '0;

   // ------------------------------------------------------------
   // metronome: period = memLen * num / den samples
   // ------------------------------------------------------------
   logic [21:0] metCnt_q;
   wire [21:0] metPeriod = 22'(({17'h0, memLen} * {31'h0, numVal}) >> den_q);
   wire metHit = advance && (metCnt_q + 22'h1 >= metPeriod);
   logic [15:0] pulseCnt_q;

   // ------------------------------------------------------------
   // loop-hold request and mode
   // ------------------------------------------------------------
   logic holdReq_q;
   lhm_pkg::lhm_mode_e mode_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         halfPh_q <= 1'b0;
         tickPend_q <= 1'b0;
         wr_q <= '0;
         metCnt_q <= '0;
      end else begin
         if (sampleTick) halfPh_q <= ~halfPh_q;
         if (rateTick) tickPend_q <= 1'b1;
         else if (advance) tickPend_q <= 1'b0;
         if (advance) wr_q <= (wr_q + 17'h1) & addrMask;
         if (metHit) metCnt_q <= '0;
         else if (advance && wrapNow && num_q == 3'h0) metCnt_q <= '0;
         else if (advance) metCnt_q <= metCnt_q + 22'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tap_q <= lhm_pkg::TAP_RESET;
         chord_q <= 1'b0;
         rpt_q <= '0;
      end else begin
         if (!upLvl) chord_q <= 1'b0;
         else if (downPress) chord_q <= 1'b1;
         if (upPress || downPress || !(upLvl || downLvl) || rptLimit)
            rpt_q <= '0;
         else rpt_q <= rpt_q + 26'h1;
         if (incTap) tap_q <= tap_q + 9'h1;
         else if (decTap) tap_q <= tap_q - 9'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         num_q <= lhm_pkg::NUM_RESET;
         den_q <= lhm_pkg::DEN_RESET;
      end else begin
         if (ratioUp)
            den_q <= (den_q == lhm_pkg::DEN_LAST) ? 3'h0 : den_q + 3'h1;
         if (ratioDown)
            num_q <= (num_q == lhm_pkg::NUM_LAST) ? 3'h0 : num_q + 3'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         holdReq_q <= 1'b0;
         mode_q <= lhm_pkg::LHM_NORMAL;
         pulseCnt_q <= '0;
      end else begin
         if (metHit) holdReq_q <= holdPress;
         else if (holdPress) holdReq_q <= ~holdReq_q;
         if (metHit && holdReq_q) begin
            case (mode_q)
               lhm_pkg::LHM_NORMAL: mode_q <= lhm_pkg::LHM_HOLD;
               lhm_pkg::LHM_HOLD: mode_q <= lhm_pkg::LHM_NORMAL;
               default: mode_q <= lhm_pkg::LHM_NORMAL;
            endcase
         end
         if (metHit) pulseCnt_q <= 16'(PULSE_CYC);
         else if (pulseCnt_q != 16'h0) pulseCnt_q <= pulseCnt_q - 16'h1;
      end
   end

   // ------------------------------------------------------------
   // read data capture and outputs
   // ------------------------------------------------------------
   logic rdValid_q;
   logic [AW-1:0] memRdAddr_q;
   logic [AW-1:0] memWrAddr_q;
   logic memWrEn_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdValid_q <= 1'b0;
         memRdAddr_q <= '0;
         memWrAddr_q <= '0;
         memWrEn_q <= 1'b0;
      end else begin
         rdValid_q <= advance;
         memWrEn_q <= advance;
         if (advance) begin
            memRdAddr_q <= rdAddr;
            memWrAddr_q <= wr_q;
         end
      end
   end

   lhm_skid_buf #(
      .W(lhm_pkg::DATA_W)
   ) u_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .inValid(rdValid_q),
      .inReady(bufReady),
      .inData(memRdData),
      .outValid(echoValid),
      .outReady(echoReady),
      .outData(echoData)
   );

   assign memRdAddr = memRdAddr_q;
   assign memWrAddr = memWrAddr_q;
   assign memRdEn = memWrEn_q;
   assign memWrEn = memWrEn_q;
   // in hold the writer stores what the full-memory read returns
   assign holdActive = (mode_q == lhm_pkg::LHM_HOLD);
   assign memWrRecirc = holdActive;
   assign tapLevel = tap_q;
   assign ratioNumSel = num_q;
   assign ratioDenSel = den_q;
   assign clkLamp = (pulseCnt_q != 16'h0);
   assign clkOutPulse = (pulseCnt_q != 16'h0);
endmodule : lhm_loop_ctrl
`default_nettype wire

// ### tb/lhm_ctrl_properties.sv
/*
 port checker for lhm_loop_ctrl.
 assumes it is bound to every instance of that module.
*/
`default_nettype none
module lhm_ctrl_properties #(
   parameter int PULSE_CYC = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // levels
   input wire logic memExtFitted,
   input wire logic echoReady,
   // memory side
   input wire logic [16:0] memWrAddr,
   input wire logic [16:0] memRdAddr,
   input wire logic memRdEn,
   input wire logic memWrRecirc,
   // stream and status
   input wire logic echoValid,
   input wire logic [15:0] echoData,
   input wire logic holdActive,
   input wire logic [8:0] tapLevel,
   input wire logic [2:0] ratioNumSel,
   input wire logic [2:0] ratioDenSel,
   input wire logic clkLamp,
   input wire logic clkOutPulse
);
   // ---------------------------
   // helpers and properties
   // ---------------------------
   logic [16:0] expRd;
   logic [15:0] lampLen_q;
   // read address from write address and tap fraction of the loop
   assign expRd = memExtFitted ? memWrAddr - {tapLevel[7:0], 9'h000}
      : {1'b0, memWrAddr[15:0] - {tapLevel[7:0], 8'h00}};
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) lampLen_q <= 16'h0000;
      else lampLen_q <= clkLamp ? lampLen_q + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_beat;
      ##[0:1] clkLamp;
   endsequence
   a_lamp_jack: assert property (clkLamp == clkOutPulse)
      else $error("lamp and jack differ");
   a_pulse_width: assert property (
      $fell(clkLamp) |-> lampLen_q == PULSE_CYC)
      else $error("pulse width wrong");
   a_hold_on_beat: assert property (
      $changed(holdActive) |-> s_beat)
      else $error("hold changed off beat");
   a_recirc_mode: assert property (memWrRecirc == holdActive)
      else $error("recirculation not following mode");
   a_hold_whole_loop: assert property (
      memRdEn && memWrRecirc && $past(memWrRecirc, 2)
      |-> memRdAddr == memWrAddr)
      else $error("hold loop shorter than memory");
   a_tap_offset: assert property (
      memRdEn && !memWrRecirc && !$past(memWrRecirc, 2)
      && $past(tapLevel, 2) == tapLevel && $stable(tapLevel)
      && $past(memExtFitted, 2) == memExtFitted |-> memRdAddr == expRd)
      else $error("read offset wrong");
   a_echo_stall: assert property (
      echoValid && !echoReady |=> echoValid && $stable(echoData))
      else $error("echo word dropped in stall");
   a_tap_range: assert property (
      tapLevel != 9'h000 && tapLevel <= 9'h100)
      else $error("tap out of range");
   a_ratio_range: assert property (
      ratioNumSel <= 3'h4 && ratioDenSel <= 3'h6)
      else $error("ratio out of range");
endmodule : lhm_ctrl_properties
bind lhm_loop_ctrl lhm_ctrl_properties #(.PULSE_CYC(PULSE_CYC)) u_props (
   .clk, .sys_rst, .memExtFitted, .echoReady, .memWrAddr, .memRdAddr,
   .memRdEn, .memWrRecirc, .echoValid, .echoData, .holdActive,
   .tapLevel, .ratioNumSel, .ratioDenSel, .clkLamp, .clkOutPulse);
`default_nettype wire

// ### tb/lhm_panel_model.sv
/*
 far side: sample memory with an address pattern and a stallable sink.
 assumes the clock of the block.
*/
`default_nettype none
module lhm_panel_model (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic stall,
   // memory
   input wire logic [16:0] memRdAddr,
   input wire logic memRdEn,
   output logic [15:0] memRdData,
   // stream
   input wire logic echoValid,
   input wire logic [15:0] echoData,
   output logic echoReady,
   // results
   output int errCount,
   output int depth
);
   // ---------------------------
   // memory and sink
   // ---------------------------
   logic [15:0] want[$];
   logic [15:0] word;
   assign word = memRdAddr[15:0] ^ {memRdAddr[16], 15'h1a3c};
   // idle bus shows the inverse, never a stale word
   assign memRdData = memRdEn ? word : ~word;
   assign echoReady = !stall;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         want.delete();
         errCount = 0;
      end else begin
         if (echoValid && echoReady) begin
            if (want.size() == 0 || want[0] !== echoData) errCount++;
            if (want.size() != 0) void'(want.pop_front());
         end
         if (memRdEn) want.push_back(word);
      end
      depth = want.size();
   end
endmodule : lhm_panel_model
`default_nettype wire

// ### tb/lhm_loop_ctrl_bench.sv
/*
 self-checking bench for lhm_loop_ctrl.
 assumes shortened counts: debounce 4, ramp 8, auto 16, pulse 3.
*/
`default_nettype none
module lhm_loop_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------
   // wiring
   // ---------------------------
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] btn = 3'h0;
   logic setMode = 1'b0;
   logic dbl = 1'b0;
   logic ext = 1'b0;
   logic tickOn = 1'b0;
   logic tick = 1'b0;
   logic stall = 1'b0;
   logic [16:0] memWrAddr, memRdAddr;
   logic memRdEn, memWrEn, memWrRecirc, echoValid, echoReady;
   logic [15:0] memRdData, echoData;
   logic holdActive, clkLamp, clkJack;
   logic [8:0] tapLevel;
   logic [2:0] ratioNumSel, ratioDenSel;
   int errCount, depth, smpCnt, cycCnt;
   int badCount = 0;
   int checked = 0;
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      tick <= tickOn && !tick;
      cycCnt <= cycCnt + 1;
      if (memWrEn === 1'b1) smpCnt <= smpCnt + 1;
   end
   lhm_loop_ctrl #(.RAMP_CYC(8), .AUTO_CYC(16), .DEBOUNCE_CYC(4),
      .PULSE_CYC(3)) u_lhm_loop_ctrl (.clk, .sys_rst,
      .stepUpBtn(btn[0]), .stepDownBtn(btn[1]), .holdBtn(btn[2]),
      .setModeClk(setMode), .delayDoublingButton(dbl),
      .memExtFitted(ext), .sampleTick(tick), .memWrAddr, .memRdAddr,
      .memRdEn, .memWrEn, .memWrRecirc, .memRdData, .echoValid,
      .echoReady, .echoData, .holdActive, .tapLevel, .ratioNumSel,
      .ratioDenSel, .clkLamp, .clkOutPulse(clkJack));
   lhm_panel_model u_lhm_panel_model (.clk, .sys_rst, .stall,
      .memRdAddr, .memRdEn, .memRdData, .echoValid, .echoData,
      .echoReady, .errCount, .depth);
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic closeOut();
      if (badCount == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : closeOut
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic press(input int b);
      cyc(1);
      btn[b] <= 1'b1;
      cyc(10);
      btn[b] <= 1'b0;
      cyc(12);
      @(negedge clk);
   endtask : press
   task automatic waitRise();
      int n = 0;
      logic was = 1'b1;
      while (!(was === 1'b0 && clkLamp === 1'b1)) begin
         was = clkLamp;
         @(negedge clk);
         n++;
         if (n > 20000) begin
            cmp(n, 0);
            closeOut();
         end
      end
   endtask : waitRise
   task automatic measure(input int expS, input int expC);
      int s;
      int c;
      waitRise();
      s = smpCnt;
      c = cycCnt;
      waitRise();
      cmp(smpCnt - s, expS);
      cmp(cycCnt - c, expC);
   endtask : measure
   task automatic ratioSteps();
      cyc(1);
      setMode <= 1'b1;
      for (int i = 1; i <= 12; i++) begin
         press(lhm_pkg::BTN_UP);
         cmp(ratioDenSel, (1 + i) % 7);
      end
      for (int i = 1; i <= 5; i++) begin
         press(lhm_pkg::BTN_DOWN);
         cmp(ratioNumSel, i % 5);
      end
      cyc(1);
      setMode <= 1'b0;
   endtask : ratioSteps
   task automatic rampMax();
      int n = 0;
      cyc(1);
      btn[0] <= 1'b1;
      cyc(10);
      btn[1] <= 1'b1;
      while (tapLevel !== 9'h100 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      cmp(n < 2100, 1'b1);
      cyc(40);
      btn[1] <= 1'b0;
      cyc(12);
      btn[0] <= 1'b0;
      cyc(12);
      @(negedge clk);
      cmp(tapLevel, 9'h100);
   endtask : rampMax
   task automatic metronome();
      measure(1024, 2048);
      press(lhm_pkg::BTN_DOWN);
      cmp(tapLevel, 9'h0ff);
      measure(1024, 2048);
      cyc(1);
      dbl <= 1'b1;
      measure(1024, 4096);
      cyc(1);
      dbl <= 1'b0;
      ext <= 1'b1;
      measure(2048, 4096);
      cyc(1);
      ext <= 1'b0;
   endtask : metronome
   task automatic holdLoop();
      for (int i = 0; i < 2; i++) begin
         waitRise();
         press(lhm_pkg::BTN_HOLD);
         cmp(holdActive, i);
         waitRise();
         repeat (2) @(negedge clk);
         cmp(holdActive, 1 - i);
         cmp(memWrRecirc, 1 - i);
      end
   endtask : holdLoop
   task automatic stallDrain();
      cyc(1);
      stall <= 1'b1;
      cyc(40);
      stall <= 1'b0;
      tickOn <= 1'b0;
      cyc(20);
      @(negedge clk);
      cmp(errCount, 0);
      cmp(depth, 0);
   endtask : stallDrain
   initial begin
      repeat (100000) @(posedge clk);
      cmp(1, 0);
      closeOut();
   end
   initial begin
      cyc(3);
      sys_rst <= 1'b0;
      tickOn <= 1'b1;
      @(negedge clk);
      cmp(ratioDenSel, 3'h1);
      cmp(ratioNumSel, 3'h0);
      ratioSteps();
      rampMax();
      metronome();
      holdLoop();
      stallDrain();
      closeOut();
   end
endmodule : lhm_loop_ctrl_bench
`default_nettype wire
